//--- verilog/slg_defines.vh
// Register offsets, field layouts, reset values and timing counts of the speed loop block
`ifndef SLG_DEFINES_VH
`define SLG_DEFINES_VH
// Printed offsets are word indices (some odd): byte address = 4 x index
`define SLG_IDX_FULL_SCALE      12'h022
`define SLG_IDX_P_GAIN          12'h130
`define SLG_IDX_I_GAIN          12'h134
`define SLG_IDX_FF_GAIN         12'h136
`define SLG_IDX_TUNING          12'h141
`define SLG_IDX_INERTIA         12'h143
`define SLG_IDX_FIRST_LOOP      12'h144
`define SLG_IDX_LOWPASS         12'h145
`define SLG_IDX_SECOND_LOOP     12'h146
`define SLG_IDX_STATUS          12'h147
`define SLG_IDX_CONTROL         12'h148
`define SLG_IDX_TORQUE          12'h149
// Preset slots are write-only and share the first index with the torque read-back
`define SLG_IDX_PRESET_1        12'h149
`define SLG_IDX_PRESET_2        12'h14A
`define SLG_IDX_PRESET_3        12'h14B
// Reset values
`define SLG_RST_FULL_SCALE      16'h0BB8
`define SLG_RST_P_GAIN          16'h01F6
`define SLG_RST_I_GAIN          16'h0032
`define SLG_RST_FF_GAIN         16'h0000
`define SLG_RST_TUNING          16'h0000
`define SLG_RST_INERTIA         16'h000A
`define SLG_RST_FIRST_LOOP      16'h0064
`define SLG_RST_LOWPASS         16'h0064
`define SLG_RST_SECOND_LOOP     16'h0064
// Limits
`define SLG_MAX_P_GAIN          16'h1FFF
`define SLG_MAX_I_GAIN          16'h03FF
`define SLG_MAX_FF_GAIN         16'h0064
`define SLG_MAX_TUNING          16'h0002
`define SLG_VOLT_DIV            10
// Tuning modes
`define SLG_TUNE_MANUAL         2'h0
`define SLG_TUNE_AUTO           2'h1
`define SLG_TUNE_SEMI           2'h2
// Control register bits
`define SLG_CTL_SERVO_ON        0
`define SLG_CTL_TORQUE_MODE     1
`define SLG_CTL_INTERNAL_SPEED  2
// Timing
`define SLG_SAVE_MINUTES        30
`define SLG_CLK_HZ              200000000
`define SLG_CTRL_PERIOD_NS      1000
`define SLG_CLK_NS              5
`define SLG_CTRL_CYCLES         (`SLG_CTRL_PERIOD_NS / `SLG_CLK_NS)
`endif

//--- verilog/slg_tick.v
// Divider that gives a one-cycle enable every DIV clocks
`default_nettype none
module slg_tick #(
	parameter [39:0] DIV = 40'hC8
) (
	input  wire clk_i,
	input  wire rst_i,
	input  wire en_i,
	output reg  tick_o
);
	reg [39:0] cnt;

	always @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt    <= 40'h0;
			tick_o <= 1'b0;
		end else if (cnt >= DIV - 40'h1) begin
			cnt    <= 40'h0;
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt + 40'h1;
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- verilog/slg_sync.v
// Three-stage synchroniser; output changes when stages two and three agree
`default_nettype none
module slg_sync #(
	parameter integer W = 1
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	integer k;

	always @(posedge clk_i) begin
		if (rst_i) begin
			s1  <= {W{1'b0}};
			s2  <= {W{1'b0}};
			s3  <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			for (k = 0; k < W; k = k + 1) begin
				if (s2[k] == s3[k])
					q_o[k] <= s3[k];
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/slg_speed_loop.v
// Speed loop: analog scaling, command select, tuning hand-over and PI+FF loop
// How it works
// - Speed command from reference minus analog ground
// - Speed mode: command = volts x full scale / 10
// - Torque mode: speed limit uses same scaling
// - Full-scale setting 16 bit, servo-off writes only
// - Internal speed mode forces first command zero
// - After servo-on, select bits pick the command
// - Tuning selector 0..2, default 0, servo-off only
// - Manual tuning uses user-written gain values
// - Auto to manual saves inertia, derives gains
// - Auto tuning stores inertia every 30 minutes
// - Auto to manual copies first, P, I
// - Semi to manual also copies lowpass, second
// - Semi tuning: converged sets flag, stops, stores
// - Semi tuning: wide variation keeps flag zero
// - Entering semi tuning restarts the estimate
// - P gain 0..8191, default 502, manual
// - I gain 0..1023, default 50
// - Feed-forward 0..100 percent, default 0
`include "slg_defines.vh"
`default_nettype none
module slg_speed_loop #(
	// Thirty minutes of clocks does not fit 32 bits, so the count is a 40-bit value
	parameter [39:0]  SAVE_CYCLES = `SLG_SAVE_MINUTES * 40'h3C * `SLG_CLK_HZ,
	parameter integer CTRL_CYCLES = `SLG_CTRL_CYCLES,
	parameter integer STABLE_TOL  = 2
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [13:0] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// Analog converter samples, signed millivolts
	input  wire [15:0] ref_mv_i,
	input  wire [15:0] analog_ground_input_i,
	// Speed select pins and feedback
	input  wire        speed_select_bit_low_i,
	input  wire        speed_select_bit_high_i,
	input  wire [15:0] measured_speed_i,
	input  wire [15:0] inertia_estimate_i,
	// Loop outputs
	output reg  [15:0] speed_command_o,
	output reg  [15:0] speed_limit_o,
	output reg  [31:0] torque_demand_o
);
	// Registers
	reg [15:0] analog_full_scale_speed;
	reg [15:0] speed_proportional_gain;
	reg [15:0] speed_integral_gain;
	reg [15:0] speed_feedforward_gain;
	reg [1:0]  gain_tuning_method;
	reg [15:0] load_inertia_ratio;
	reg [15:0] first_loop_gain_setting;
	reg [15:0] lowpass_filter_setting;
	reg [15:0] second_loop_setting;
	reg [2:0]  control;
	reg        inertia_converged_flag;
	reg [15:0] preset_speed [0:2];
	// Tuning internals
	reg [1:0]  prev_method;
	reg        estimating;
	reg [15:0] last_est;
	reg [3:0]  stable_cnt;
	reg [47:0] integ;
	wire       save_tick;
	wire       ctrl_tick;
	wire [1:0] sel_sync;
	wire [15:0] fs_word;

	wire servo_on   = control[`SLG_CTL_SERVO_ON];
	wire torque_md  = control[`SLG_CTL_TORQUE_MODE];
	wire internal_m = control[`SLG_CTL_INTERNAL_SPEED];
	wire wb_req     = cyc_i && stb_i && !ack_o;
	wire wb_wr      = wb_req && we_i && sel_i[0] && sel_i[1];
	wire [11:0] idx = adr_i[13:2];

	slg_sync #(
		.W (2)
	) u_sel_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({speed_select_bit_high_i, speed_select_bit_low_i}),
		.q_o   (sel_sync)
	);

	slg_tick #(
		.DIV (SAVE_CYCLES)
	) u_save_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (gain_tuning_method == `SLG_TUNE_AUTO),
		.tick_o (save_tick)
	);

	slg_tick #(
		.DIV (CTRL_CYCLES)
	) u_ctrl_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.en_i   (1'b1),
		.tick_o (ctrl_tick)
	);

	// Analog scaling
	wire signed [16:0] volt_mv  = $signed({ref_mv_i[15], ref_mv_i}) -
		$signed({analog_ground_input_i[15], analog_ground_input_i});
	wire signed [34:0] prod     = volt_mv * $signed({1'b0, analog_full_scale_speed});
	wire signed [34:0] scaled   = prod / $signed(35'd10000);
	wire [15:0] analog_cmd      = scaled[15:0];
	wire [15:0] first_cmd       = internal_m ? 16'h0000 : analog_cmd;
	reg  [15:0] next_cmd;

	always @* begin
		case (sel_sync)
			2'h0: next_cmd = first_cmd;
			2'h1: next_cmd = preset_speed[0];
			2'h2: next_cmd = preset_speed[1];
			2'h3: next_cmd = preset_speed[2];
			default: next_cmd = 16'h0000;
		endcase
		if (!servo_on)
			next_cmd = 16'h0000;
	end

	wire leaving_auto = (prev_method == `SLG_TUNE_AUTO) && (gain_tuning_method == `SLG_TUNE_MANUAL);
	wire leaving_semi = (prev_method == `SLG_TUNE_SEMI) && (gain_tuning_method == `SLG_TUNE_MANUAL);
	wire entering_semi = (prev_method != `SLG_TUNE_SEMI) && (gain_tuning_method == `SLG_TUNE_SEMI);

	// Gains derived from inertia on hand-over; simple scaling, the estimator is outside
	// Derive from the ratio saved at this hand-over, never from a stale register value
	wire [15:0] handover_ratio = (estimating || leaving_auto) ? inertia_estimate_i : load_inertia_ratio;
	wire [16:0] derived_sum    = {1'b0, first_loop_gain_setting} + {1'b0, handover_ratio[11:0], 4'h0};
	// Saturate so a large first-loop setting cannot push P beyond its range
	wire [15:0] derived_p      = (handover_ratio > 16'h00FF || derived_sum > {1'b0, `SLG_MAX_P_GAIN}) ?
		`SLG_MAX_P_GAIN : derived_sum[15:0];
	wire [15:0] derived_i  = (first_loop_gain_setting > `SLG_MAX_I_GAIN) ? `SLG_MAX_I_GAIN : first_loop_gain_setting;
	wire [15:0] est_diff   = (inertia_estimate_i > last_est) ? inertia_estimate_i - last_est
		: last_est - inertia_estimate_i;

	// Register file and tuning
	always @(posedge clk_i) begin
		if (rst_i) begin
			analog_full_scale_speed <= `SLG_RST_FULL_SCALE;
			speed_proportional_gain <= `SLG_RST_P_GAIN;
			speed_integral_gain     <= `SLG_RST_I_GAIN;
			speed_feedforward_gain  <= `SLG_RST_FF_GAIN;
			gain_tuning_method      <= 2'h0;
			load_inertia_ratio      <= `SLG_RST_INERTIA;
			first_loop_gain_setting <= `SLG_RST_FIRST_LOOP;
			lowpass_filter_setting  <= `SLG_RST_LOWPASS;
			second_loop_setting     <= `SLG_RST_SECOND_LOOP;
			control                 <= 3'h0;
			inertia_converged_flag  <= 1'b0;
			preset_speed[0]         <= 16'h0000;
			preset_speed[1]         <= 16'h0000;
			preset_speed[2]         <= 16'h0000;
			prev_method             <= 2'h0;
			estimating              <= 1'b0;
			last_est                <= 16'h0000;
			stable_cnt              <= 4'h0;
		end else begin
			prev_method <= gain_tuning_method;
			if (wb_wr) begin
				case (idx)
					`SLG_IDX_FULL_SCALE: begin
						if (!servo_on)
							analog_full_scale_speed <= dat_i[15:0];
					end
					`SLG_IDX_P_GAIN: begin
						if (dat_i[15:0] <= `SLG_MAX_P_GAIN)
							speed_proportional_gain <= dat_i[15:0];
					end
					`SLG_IDX_I_GAIN: begin
						if (dat_i[15:0] <= `SLG_MAX_I_GAIN)
							speed_integral_gain <= dat_i[15:0];
					end
					`SLG_IDX_FF_GAIN: begin
						if (dat_i[15:0] <= `SLG_MAX_FF_GAIN)
							speed_feedforward_gain <= dat_i[15:0];
					end
					// Refused values are dropped silently, the cycle is still acked
					`SLG_IDX_TUNING: begin
						if (!servo_on && dat_i[15:0] <= `SLG_MAX_TUNING)
							gain_tuning_method <= dat_i[1:0];
					end
					`SLG_IDX_INERTIA: begin
						load_inertia_ratio <= dat_i[15:0];
					end
					`SLG_IDX_FIRST_LOOP: begin
						first_loop_gain_setting <= dat_i[15:0];
					end
					`SLG_IDX_LOWPASS: begin
						lowpass_filter_setting <= dat_i[15:0];
					end
					`SLG_IDX_SECOND_LOOP: begin
						second_loop_setting <= dat_i[15:0];
					end
					`SLG_IDX_CONTROL: begin
						control <= dat_i[2:0];
					end
					// Presets cannot be read back; their first slot reads as torque
					`SLG_IDX_PRESET_1: begin
						preset_speed[0] <= dat_i[15:0];
					end
					`SLG_IDX_PRESET_2: begin
						preset_speed[1] <= dat_i[15:0];
					end
					`SLG_IDX_PRESET_3: begin
						preset_speed[2] <= dat_i[15:0];
					end
					default: begin
					end
				endcase
			end
			// Hardware updates come after bus writes so they win on a collision
			if (gain_tuning_method == `SLG_TUNE_AUTO && save_tick)
				load_inertia_ratio <= inertia_estimate_i;
			if (entering_semi) begin
				estimating             <= 1'b1;
				inertia_converged_flag <= 1'b0;
				stable_cnt             <= 4'h0;
			end else if (gain_tuning_method == `SLG_TUNE_SEMI && estimating && ctrl_tick) begin
				last_est <= inertia_estimate_i;
				if (est_diff > STABLE_TOL) begin
					stable_cnt             <= 4'h0;
					inertia_converged_flag <= 1'b0;
				end else if (stable_cnt == 4'hF) begin
					inertia_converged_flag <= 1'b1;
					estimating             <= 1'b0;
					load_inertia_ratio     <= inertia_estimate_i;
				end else begin
					stable_cnt <= stable_cnt + 4'h1;
				end
			end
			if (leaving_auto || leaving_semi) begin
				if (estimating || leaving_auto)
					load_inertia_ratio <= inertia_estimate_i;
				first_loop_gain_setting <= derived_p;
				speed_proportional_gain <= derived_p;
				speed_integral_gain     <= derived_i;
				estimating              <= 1'b0;
			end
			if (leaving_semi) begin
				lowpass_filter_setting <= derived_p;
				second_loop_setting    <= derived_p;
			end
		end
	end

	// Bus answer: one wait-free ack, unmapped reads return zero
	reg [15:0] rd;
	always @* begin
		case (idx)
			`SLG_IDX_FULL_SCALE: begin
				rd = analog_full_scale_speed;
			end
			`SLG_IDX_P_GAIN: begin
				rd = speed_proportional_gain;
			end
			`SLG_IDX_I_GAIN: begin
				rd = speed_integral_gain;
			end
			`SLG_IDX_FF_GAIN: begin
				rd = speed_feedforward_gain;
			end
			`SLG_IDX_TUNING: begin
				rd = {14'h0000, gain_tuning_method};
			end
			`SLG_IDX_INERTIA: begin
				rd = load_inertia_ratio;
			end
			`SLG_IDX_FIRST_LOOP: begin
				rd = first_loop_gain_setting;
			end
			`SLG_IDX_LOWPASS: begin
				rd = lowpass_filter_setting;
			end
			`SLG_IDX_SECOND_LOOP: begin
				rd = second_loop_setting;
			end
			`SLG_IDX_STATUS: begin
				rd = {14'h0000, estimating, inertia_converged_flag};
			end
			`SLG_IDX_CONTROL: begin
				rd = {13'h0000, control};
			end
			`SLG_IDX_TORQUE: begin
				rd = torque_demand_o[15:0];
			end
			default: begin
				rd = 16'h0000;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= wb_req;
			dat_o <= wb_req ? {16'h0000, rd} : 32'h0000_0000;
		end
	end

	// Control loop
	wire signed [16:0] err   = $signed({speed_command_o[15], speed_command_o}) -
		$signed({measured_speed_i[15], measured_speed_i});
	wire signed [33:0] p_term = err * $signed({1'b0, speed_proportional_gain});
	wire signed [33:0] i_step = err * $signed({1'b0, speed_integral_gain});
	wire signed [33:0] ff_raw = $signed({speed_command_o[15], speed_command_o}) *
		$signed({1'b0, speed_feedforward_gain});
	wire signed [33:0] ff_term = ff_raw / $signed(34'd100);
	wire signed [47:0] next_integ = $signed(integ) + {{14{i_step[33]}}, i_step};
	wire signed [47:0] sum = {{14{p_term[33]}}, p_term} + next_integ + {{14{ff_term[33]}}, ff_term};

	always @(posedge clk_i) begin
		if (rst_i) begin
			speed_command_o <= 16'h0000;
			speed_limit_o   <= 16'h0000;
			torque_demand_o <= 32'h0000_0000;
			integ           <= 48'h0;
		end else begin
			speed_command_o <= torque_md ? 16'h0000 : next_cmd;
			speed_limit_o   <= torque_md ? analog_cmd : 16'h0000;
			if (!servo_on) begin
				integ           <= 48'h0;
				torque_demand_o <= 32'h0000_0000;
			end else if (ctrl_tick) begin
				integ           <= next_integ;
				torque_demand_o <= sum[31:0];
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/slg_ref_model.sv
// Host controller model that drives the differential analog reference samples
`default_nettype none
module slg_ref_src (
	// Clock and target
	input  wire logic        clk_i,
	input  wire logic [15:0] diff_mv_i,
	input  wire logic [15:0] gnd_mv_i,
	// Converter samples
	output var  logic [15:0] ref_mv_o,
	output var  logic [15:0] gnd_mv_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ground sits off zero so a design that ignores it gives a wrong command
	always @(posedge clk_i) begin
		gnd_mv_o <= gnd_mv_i;
		ref_mv_o <= gnd_mv_i + diff_mv_i;
	end
endmodule
`default_nettype wire

//--- testbench/slg_monitor.sv
// Bus handshake and register range checker for the speed loop block
`default_nettype none
module slg_monitor (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Wishbone
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [13:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire [11:0] idx = adr_i[13:2];
	wire        rd = ack_o && !we_i;
	sequence s_req; cyc_i && stb_i && !ack_o; endsequence
	sequence s_ans; ack_o ##1 !ack_o; endsequence
	chk_ack_next: assert property (s_req |=> s_ans)
		else $error("request without one-cycle ack");
	chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	chk_upper_zero: assert property (rd |-> dat_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	chk_unmapped_zero: assert property (rd && idx == 12'h000 |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_p_range: assert property (rd && idx == 12'h130 |-> dat_o[15:0] <= 16'h1FFF)
		else $error("P gain out of range");
	chk_i_range: assert property (rd && idx == 12'h134 |-> dat_o[15:0] <= 16'h03FF)
		else $error("I gain out of range");
	chk_ff_range: assert property (rd && idx == 12'h136 |-> dat_o[15:0] <= 16'h0064)
		else $error("feed-forward out of range");
	chk_tune_range: assert property (rd && idx == 12'h141 |-> dat_o[15:0] <= 16'h0002)
		else $error("tuning method out of range");
endmodule
bind slg_speed_loop slg_monitor slg_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o));
`default_nettype wire

//--- testbench/tb_speed_loop_gain_and_analog_scaling.sv
// Self-checking bench for the speed loop block
`default_nettype none
module tb_speed_loop_gain_and_analog_scaling;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0, ack;
	logic [13:0] adr = 14'h0000;
	logic [31:0] dat_w = 32'h0, dat_r, torque;
	logic [15:0] meas = 16'h0, est = 16'h0, diff = 16'h0, ref_mv, gnd_mv, cmd, lim;
	int          n_fail = 0, compares = 0, ticks = 0;
	always #2.5 clk_i = ~clk_i;
	slg_ref_src slg_ref_src_i (.clk_i(clk_i), .diff_mv_i(diff), .gnd_mv_i(16'h01F4), .ref_mv_o(ref_mv),
		.gnd_mv_o(gnd_mv));
	// Short save and control periods keep the run brief
	slg_speed_loop #(.SAVE_CYCLES(50), .CTRL_CYCLES(4)) slg_speed_loop_i (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat_w), .dat_o(dat_r),
		.ack_o(ack), .ref_mv_i(ref_mv), .analog_ground_input_i(gnd_mv), .speed_select_bit_low_i(sel_lo),
		.speed_select_bit_high_i(sel_hi), .measured_speed_i(meas), .inertia_estimate_i(est),
		.speed_command_o(cmd), .speed_limit_o(lim), .torque_demand_o(torque));
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// One classic cycle; waits for ack and releases only after it
	task automatic wb(input logic w, input logic [11:0] i, input logic [15:0] d, output logic [15:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat_w <= {16'h0000, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		q = dat_r[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wreg(input logic [11:0] i, input logic [15:0] d);
		logic [15:0] q;
		wb(1'b1, i, d, q);
	endtask
	task automatic rreg(input logic [11:0] i, input logic [15:0] e);
		logic [15:0] q;
		wb(1'b0, i, 16'h0000, q);
		chk($sformatf("reg %h", i), e, q);
	endtask
	task automatic t_defaults;
		rreg(12'h022, 16'h0BB8);
		rreg(12'h130, 16'h01F6);
		rreg(12'h134, 16'h0032);
		rreg(12'h136, 16'h0000);
		rreg(12'h141, 16'h0000);
		rreg(12'h000, 16'h0000);
	endtask
	task automatic t_limits;
		logic [11:0] ix[3] = '{12'h130, 12'h134, 12'h136};
		logic [15:0] top[3] = '{16'h1FFF, 16'h03FF, 16'h0064};
		for (int k = 0; k < 3; k++) begin
			wreg(ix[k], top[k]);
			wreg(ix[k], top[k] + 16'h0001);
			rreg(ix[k], top[k]);
		end
	endtask
	task automatic t_auto;
		est <= 16'h001E;
		wreg(12'h141, 16'h0001);
		idle(80);
		rreg(12'h143, 16'h001E);
		wreg(12'h141, 16'h0003);
		rreg(12'h141, 16'h0001);
		wreg(12'h141, 16'h0000);
		rreg(12'h130, 16'h0244);
		rreg(12'h134, 16'h0064);
		rreg(12'h144, 16'h0244);
		rreg(12'h145, 16'h0064);
	endtask
	task automatic t_semi;
		wreg(12'h143, 16'h0028);
		wreg(12'h141, 16'h0002);
		repeat (30) begin
			est <= est + 16'h0032;
			idle(4);
		end
		rreg(12'h147, 16'h0002);
		est <= 16'h002D;
		idle(120);
		rreg(12'h147, 16'h0001);
		rreg(12'h143, 16'h002D);
		wreg(12'h141, 16'h0000);
		rreg(12'h130, 16'h0514);
		rreg(12'h134, 16'h0244);
		rreg(12'h145, 16'h0514);
		rreg(12'h146, 16'h0514);
	endtask
	task automatic t_loop;
		diff <= 16'h1388;
		wreg(12'h148, 16'h0001);
		idle(10);
		chk("speed command", 16'h05DC, cmd);
		wreg(12'h022, 16'h03E8);
		rreg(12'h022, 16'h0BB8);
		wreg(12'h141, 16'h0001);
		rreg(12'h141, 16'h0000);
		diff <= 16'hF63C;
		idle(10);
		chk("negative command", 16'hFD12, cmd);
		wreg(12'h148, 16'h0005);
		idle(10);
		chk("internal command", 16'h0000, cmd);
		wreg(12'h148, 16'h0001);
		wreg(12'h149, 16'h02BC);
		sel_lo <= 1'b1;
		idle(10);
		chk("preset command", 16'h02BC, cmd);
		wreg(12'h14A, 16'h0190);
		wreg(12'h14B, 16'h0064);
		sel_lo <= 1'b0;
		sel_hi <= 1'b1;
		idle(10);
		chk("preset two", 16'h0190, cmd);
		sel_lo <= 1'b1;
		idle(10);
		chk("preset three", 16'h0064, cmd);
		sel_lo <= 1'b0;
		sel_hi <= 1'b0;
		diff <= 16'h1388;
		wreg(12'h148, 16'h0003);
		idle(10);
		chk("speed limit", 16'h05DC, lim);
	endtask
	// Servo off first so the integrator starts empty
	task automatic t_torque;
		wreg(12'h148, 16'h0000);
		wreg(12'h130, 16'h0002);
		wreg(12'h134, 16'h0000);
		wreg(12'h136, 16'h0000);
		meas <= 16'h03E8;
		wreg(12'h148, 16'h0001);
		idle(20);
		chk("torque", 32'h000003E8, torque);
		wreg(12'h136, 16'h0064);
		idle(20);
		chk("torque with ff", 32'h000009C4, torque);
		rreg(12'h149, 16'h09C4);
	endtask
	// Reset in mid-run must clear outputs and bring settings back to defaults
	task automatic t_reset;
		rst_i <= 1'b1;
		idle(6);
		rst_i <= 1'b0;
		idle(1);
		chk("torque after reset", 32'h00000000, torque);
		chk("command after reset", 32'h00000000, cmd);
		rreg(12'h130, 16'h01F6);
		rreg(12'h136, 16'h0000);
		rreg(12'h141, 16'h0000);
	endtask
	initial begin
		idle(6);
		rst_i <= 1'b0;
		idle(1);
		t_defaults();
		t_limits();
		t_auto();
		t_semi();
		t_loop();
		t_torque();
		t_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire
